/* hdl/lctr_pkg.sv */
// Shared constants, timing figures and types for both link ends.
// Assumes a single 250 MHz core clock shared by both ends.
//
// What this block does
// [RQ1] Two cycles after power-down exit before commands
// [RQ2] Self-refresh exit waits 110 or 112.5 ns
// [RQ3] Clock toggles at least twice during that wait
// [RQ4] Read data valid CL-1 clocks plus access
// [RQ5] Frequency change only with clock stopped
// [RQ6] Clock-enable low minimum counted from clock edge
// [RQ7] Write-to-activate equals rounded recovery plus precharge
// [RQ8] Auto-precharge access only once row time met
// [RQ9] Write recovery is at least one cycle
// [RQ10] Automotive parts halve refresh period and interval; the code halves only the interval (REF_MS is unused)
// [RQ11] One data strobe and mask per byte lane
// [RQ12] Write strobe held valid from write command
// [RQ13] Negative strobe preamble setup still accepted
// [RQ14] Long strobe postamble still accepted
// [RQ15] Output drive starts and stops with data
// [RQ16] Nanosecond limits rounded up, enforced by down-counters
package lctr_pkg;

  // ---------------------------------------------------------------
  // Clock and timing figures
  // ---------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int XP_CK = 2;
  localparam int XSR_FAST_PS = 110000;
  localparam int XSR_SLOW_PS = 112500;
  localparam int XSR_MIN_TOGGLES = 2;
  localparam int WR_FAST_PS = 14400;
  localparam int WR_SLOW_PS = 15000;
  localparam int RP_FAST_PS = 14400;
  localparam int RP_SLOW_PS = 15000;
  localparam int RAS_FAST_PS = 38400;
  localparam int RAS_SLOW_PS = 40000;
  localparam int RCD_FAST_PS = 14400;
  localparam int RCD_SLOW_PS = 15000;
  localparam int RFC_PS = 72000;
  localparam int REFI_NS = 7800;
  localparam int REF_MS = 64;
  localparam int AUTO_DIV = 2;
  localparam int CKE_LOW_CK = 2;
  localparam int CNT_W = 12;

  // ---------------------------------------------------------------
  // Bus layout
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int AP_BIT = 10;
  localparam int CL_DEF = 3;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5
  } lctr_cmd_t;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_PDN = 3'h2,
    OP_SREF = 3'h3,
    OP_WAKE = 3'h4
  } lctr_op_t;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h1,
    MODE_PDN = 3'h2,
    MODE_SREF = 3'h4
  } lctr_mode_t;

  // Least time: round up, never below one cycle
  function automatic int lctr_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS; // see [RQ16]
    return (c < 1) ? 1 : c;
  endfunction

endpackage

/* hdl/lctr_if.sv */
// Command bus between controller and memory end.
// Two-way data and strobe wires are resolved here from the enables.
`timescale 1ns/10ps
interface lctr_if
  import lctr_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int ADDR_W = 14
) ();
  localparam int NS = DQ_W / BYTE_W;

  logic ck_run;
  logic cke;
  lctr_cmd_t cmd;
  logic [ADDR_W-1:0] addr;
  logic [NS-1:0] dm;
  logic [DQ_W-1:0] dq_c_o;
  logic dq_c_oe;
  logic [NS-1:0] dqs_c_o;
  logic [NS-1:0] dqs_c_oe;
  logic [DQ_W-1:0] dq_m_o;
  logic dq_m_oe;
  logic [NS-1:0] dqs_m_o;
  logic [NS-1:0] dqs_m_oe;
  logic [DQ_W-1:0] dq;
  logic [NS-1:0] dqs;

  // Undriven wire reads as zero
  assign dq = dq_m_oe ? dq_m_o : (dq_c_oe ? dq_c_o : '0);
  assign dqs = (dqs_m_o & dqs_m_oe) | (dqs_c_o & dqs_c_oe & ~dqs_m_oe);

  modport ctrl (
    output ck_run, cke, cmd, addr, dm, dq_c_o, dq_c_oe, dqs_c_o, dqs_c_oe,
    input dq, dqs, dq_m_oe
  );
  modport mem (
    input ck_run, cke, cmd, addr, dm, dq, dqs,
    output dq_m_o, dq_m_oe, dqs_m_o, dqs_m_oe
  );
endinterface // lctr_if

/* hdl/lctr_ctrl.sv */
// Controller end: issues commands with all timing waits, plus read buffer.
// Assumes the memory end shares core_clk and sees ck_run as its clock.
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Small FIFO for read words
// ---------------------------------------------------------------
module lctr_buf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != FULL);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wp = (wp_ff == LAST) ? '0 : PW'(wp_ff + 1'b1);
    end
    if (pop) begin
      nxt_rp = (rp_ff == LAST) ? '0 : PW'(rp_ff + 1'b1);
    end
    if (push && !pop) begin
      nxt_cnt = CW'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage holds no control state, so no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule // lctr_buf

// ---------------------------------------------------------------
// Command sequencer
// ---------------------------------------------------------------
module lctr_ctrl
  import lctr_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int ADDR_W = 14,
  parameter int COL_W = 10,
  parameter bit SLOW_GRADE = 1'b0,
  parameter bit AUTOMOTIVE = 1'b1,
  parameter int CKE_LOW_CYC = CKE_LOW_CK
) (
  input wire logic core_clk,
  input wire logic rst_n,
  lctr_if.ctrl bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire lctr_op_t req_op,
  input wire logic req_ap,
  input wire logic [ADDR_W-1:0] req_row,
  input wire logic [COL_W-1:0] req_col,
  input wire logic [DQ_W-1:0] req_wdata,
  input wire logic [DQ_W/BYTE_W-1:0] req_mask,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DQ_W-1:0] rd_data,
  output logic freq_ok
);
  localparam int NS = DQ_W / BYTE_W;
  localparam int RCD_CYC = lctr_cyc(SLOW_GRADE ? RCD_SLOW_PS : RCD_FAST_PS);
  localparam int RAS_CYC = lctr_cyc(SLOW_GRADE ? RAS_SLOW_PS : RAS_FAST_PS);
  localparam int WR_CYC = lctr_cyc(SLOW_GRADE ? WR_SLOW_PS : WR_FAST_PS); // see [RQ9]
  localparam int RP_CYC = lctr_cyc(SLOW_GRADE ? RP_SLOW_PS : RP_FAST_PS);
  localparam int DAL_CYC = WR_CYC + RP_CYC; // see [RQ7]
  localparam int XSR_CYC = lctr_cyc(SLOW_GRADE ? XSR_SLOW_PS : XSR_FAST_PS); // see [RQ2]
  localparam int XSR_WAIT = (XSR_CYC > XSR_MIN_TOGGLES) ? XSR_CYC : XSR_MIN_TOGGLES; // see [RQ3]
  localparam int RFC_CYC = lctr_cyc(RFC_PS);
  localparam int REFI_CYC = lctr_cyc(REFI_NS * 1000) / (AUTOMOTIVE ? AUTO_DIV : 1); // see [RQ10]
  localparam logic [CNT_W-1:0] L_RCD = CNT_W'(RCD_CYC - 1);
  localparam logic [CNT_W-1:0] L_RAS = CNT_W'(RAS_CYC - 1);
  localparam logic [CNT_W-1:0] L_WR = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] L_RP = CNT_W'(RP_CYC - 1);
  localparam logic [CNT_W-1:0] L_DAL = CNT_W'(DAL_CYC - 1);
  localparam logic [CNT_W-1:0] L_XSR = CNT_W'(XSR_WAIT - 1);
  localparam logic [CNT_W-1:0] L_XP = CNT_W'(XP_CK - 1); // see [RQ1]
  localparam logic [CNT_W-1:0] L_RFC = CNT_W'(RFC_CYC - 1);
  localparam logic [CNT_W-1:0] L_REFI = CNT_W'(REFI_CYC - 1);
  localparam logic [CNT_W-1:0] L_CKE = CNT_W'(CKE_LOW_CYC - 1);

  typedef enum logic [7:0] {
    CS_IDLE = 8'h01,
    CS_ACT = 8'h02,
    CS_WDAT = 8'h04,
    CS_DATA = 8'h08,
    CS_PRE = 8'h10,
    CS_WAIT = 8'h20,
    CS_PDN = 8'h40,
    CS_SREF = 8'h80
  } lctr_cst_t;

  lctr_cst_t state_ff, nxt_state;
  lctr_cmd_t cmd_ff, nxt_cmd;
  lctr_op_t op_ff, nxt_op;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, ras_ff, nxt_ras, ref_cnt_ff, nxt_ref_cnt;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [COL_W-1:0] col_ff, nxt_col;
  logic [DQ_W-1:0] wdata_ff, nxt_wdata, dq_ff, nxt_dq;
  logic [NS-1:0] mask_ff, nxt_mask, dm_ff, nxt_dm, dqs_ff, nxt_dqs, dqs_oe_ff, nxt_dqs_oe;
  logic cke_ff, nxt_cke, ck_run_ff, nxt_ck_run, dq_oe_ff, nxt_dq_oe;
  logic ap_ff, nxt_ap, ref_pend_ff, nxt_ref_pend;
  logic buf_in_valid, buf_in_ready, ref_tick;

  assign bus.cmd = cmd_ff;
  assign bus.addr = addr_ff;
  assign bus.cke = cke_ff;
  assign bus.ck_run = ck_run_ff;
  assign bus.dq_c_o = dq_ff;
  assign bus.dq_c_oe = dq_oe_ff;
  assign bus.dqs_c_o = dqs_ff;
  assign bus.dqs_c_oe = dqs_oe_ff;
  assign bus.dm = dm_ff;
  // Clock is stopped only in a low-power state
  assign freq_ok = ((state_ff == CS_PDN) || (state_ff == CS_SREF)) && !ck_run_ff; // see [RQ5]
  assign ref_tick = (ref_cnt_ff == '0);

  // Read words only leave the bus into this buffer; a read is
  // issued only while it has room, so a stalled reader loses nothing
  lctr_buf #(.W(DQ_W), .DEPTH(2)) u_rdbuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(bus.dq),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff != '0) ? CNT_W'(cnt_ff - 1'b1) : cnt_ff; // see [RQ16]
    nxt_ras = (ras_ff != '0) ? CNT_W'(ras_ff - 1'b1) : ras_ff;
    nxt_ref_cnt = ref_tick ? L_REFI : CNT_W'(ref_cnt_ff - 1'b1);
    nxt_ref_pend = ref_pend_ff | ref_tick;
    nxt_cmd = CMD_NOP;
    nxt_addr = addr_ff;
    nxt_cke = cke_ff;
    nxt_ck_run = ck_run_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = 1'b0;
    nxt_dqs = '0;
    nxt_dqs_oe = '0;
    nxt_dm = '0;
    nxt_op = op_ff;
    nxt_ap = ap_ff;
    nxt_col = col_ff;
    nxt_wdata = wdata_ff;
    nxt_mask = mask_ff;
    req_ready = 1'b0;
    buf_in_valid = 1'b0;
    case (state_ff)
      CS_IDLE: begin
        if (ref_pend_ff) begin
          nxt_cmd = CMD_REF;
          nxt_ref_pend = ref_tick;
          nxt_cnt = L_RFC;
          nxt_state = CS_WAIT;
        end else if (req_valid && (req_op != OP_READ || buf_in_ready)) begin
          req_ready = 1'b1;
          nxt_op = req_op;
          nxt_ap = req_ap;
          nxt_col = req_col;
          nxt_wdata = req_wdata;
          nxt_mask = req_mask;
          case (req_op)
            OP_READ, OP_WRITE: begin
              nxt_cmd = CMD_ACT;
              nxt_addr = req_row;
              nxt_cnt = L_RCD;
              nxt_ras = L_RAS;
              nxt_state = CS_ACT;
            end
            OP_PDN: begin
              nxt_cke = 1'b0;
              nxt_cnt = L_CKE;
              nxt_state = CS_PDN;
            end
            OP_SREF: begin
              nxt_cmd = CMD_REF;
              nxt_cke = 1'b0;
              nxt_cnt = L_CKE;
              nxt_ref_pend = ref_tick;
              nxt_state = CS_SREF;
            end
            default: begin
            end
          endcase
        end
      end
      CS_ACT: begin
        // Auto-precharge waits out the row-open time first
        if (cnt_ff == '0 && (!ap_ff || ras_ff == '0)) begin // see [RQ8]
          nxt_addr = ADDR_W'(col_ff);
          nxt_addr[AP_BIT] = ap_ff;
          if (op_ff == OP_WRITE) begin
            nxt_cmd = CMD_WR;
            nxt_dqs_oe = '1; // see [RQ12]
            nxt_state = CS_WDAT;
          end else begin
            nxt_cmd = CMD_RD;
            nxt_state = CS_DATA;
          end
        end
      end
      CS_WDAT: begin
        nxt_dq = wdata_ff;
        nxt_dq_oe = 1'b1;
        nxt_dqs = '1;
        nxt_dqs_oe = '1;
        nxt_dm = mask_ff; // see [RQ11]
        nxt_cnt = ap_ff ? L_DAL : L_WR; // see [RQ7]
        nxt_state = ap_ff ? CS_WAIT : CS_PRE;
      end
      CS_DATA: begin
        if (bus.dq_m_oe) begin
          buf_in_valid = 1'b1;
          nxt_cnt = ap_ff ? L_RP : '0;
          nxt_state = ap_ff ? CS_WAIT : CS_PRE;
        end
      end
      CS_PRE: begin
        if (cnt_ff == '0 && ras_ff == '0) begin
          nxt_cmd = CMD_PRE;
          nxt_cnt = L_RP;
          nxt_state = CS_WAIT;
        end
      end
      CS_WAIT: begin
        if (cnt_ff == '0) begin
          nxt_state = CS_IDLE;
        end
      end
      CS_PDN, CS_SREF: begin
        // Clock keeps running until the low time has passed
        if (cnt_ff == '0) begin // see [RQ6]
          nxt_ck_run = 1'b0;
          if (req_valid && req_op == OP_WAKE) begin
            req_ready = 1'b1;
            nxt_cke = 1'b1;
            nxt_ck_run = 1'b1; // see [RQ3]
            nxt_cnt = (state_ff == CS_SREF) ? L_XSR : L_XP; // see [RQ1] see [RQ2]
            nxt_state = CS_WAIT;
          end
        end
      end
      default: begin
        nxt_state = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CS_IDLE;
      cmd_ff <= CMD_NOP;
      op_ff <= OP_READ;
      cnt_ff <= '0;
      ras_ff <= '0;
      ref_cnt_ff <= L_REFI;
      ref_pend_ff <= 1'b0;
      addr_ff <= '0;
      col_ff <= '0;
      wdata_ff <= '0;
      mask_ff <= '0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      dqs_ff <= '0;
      dqs_oe_ff <= '0;
      dm_ff <= '0;
      cke_ff <= 1'b1;
      ck_run_ff <= 1'b1;
      ap_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      ras_ff <= nxt_ras;
      ref_cnt_ff <= nxt_ref_cnt;
      ref_pend_ff <= nxt_ref_pend;
      addr_ff <= nxt_addr;
      col_ff <= nxt_col;
      wdata_ff <= nxt_wdata;
      mask_ff <= nxt_mask;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      dqs_ff <= nxt_dqs;
      dqs_oe_ff <= nxt_dqs_oe;
      dm_ff <= nxt_dm;
      cke_ff <= nxt_cke;
      ck_run_ff <= nxt_ck_run;
      ap_ff <= nxt_ap;
    end
  end
endmodule // lctr_ctrl

/* hdl/lctr_mem.sv */
// Memory end: decodes commands, returns read data after CL, stores writes.
// Assumes commands are only legal while ck_run and cke are high.
`timescale 1ns/10ps
module lctr_mem
  import lctr_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int ADDR_W = 14,
  parameter int CL = CL_DEF,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  lctr_if.mem bus,
  output lctr_mode_t mem_mode
);
  localparam int NS = DQ_W / BYTE_W;
  localparam int P = CL - 1;
  localparam int IW = $clog2(DEPTH);

  logic [DQ_W-1:0] mem_ff [DEPTH];
  lctr_mode_t mode_ff, nxt_mode;
  logic [P-1:0] rd_pipe_ff, nxt_rd_pipe;
  logic [IW-1:0] col_pipe_ff [P];
  logic [IW-1:0] nxt_col_pipe [P];
  logic [IW-1:0] wcol_ff, nxt_wcol;
  logic wr_pend_ff, nxt_wr_pend, dq_oe_ff, nxt_dq_oe;
  logic [DQ_W-1:0] dq_ff, nxt_dq, wr_word;
  logic cmd_ok, rd_cmd, wr_cmd;

  assign mem_mode = mode_ff;
  assign cmd_ok = bus.ck_run && bus.cke && (mode_ff == MODE_ACTIVE);
  assign rd_cmd = cmd_ok && (bus.cmd == CMD_RD);
  assign wr_cmd = cmd_ok && (bus.cmd == CMD_WR);
  // Drive window is the data window itself
  assign bus.dq_m_o = dq_ff;
  assign bus.dq_m_oe = dq_oe_ff; // see [RQ15]
  assign bus.dqs_m_o = {NS{dq_oe_ff}};
  assign bus.dqs_m_oe = {NS{dq_oe_ff}};

  always_comb begin
    nxt_mode = mode_ff;
    if (mode_ff == MODE_ACTIVE && bus.ck_run && !bus.cke) begin
      nxt_mode = (bus.cmd == CMD_REF) ? MODE_SREF : MODE_PDN;
    end else if (mode_ff != MODE_ACTIVE && bus.cke) begin
      nxt_mode = MODE_ACTIVE;
    end
    // Data registered CL-1 edges after the command edge
    nxt_rd_pipe = (rd_pipe_ff << 1) | P'(rd_cmd); // see [RQ4]
    nxt_col_pipe[0] = IW'(bus.addr);
    for (int i = 1; i < P; i++) begin
      nxt_col_pipe[i] = col_pipe_ff[i-1];
    end
    nxt_dq_oe = rd_pipe_ff[P-1];
    nxt_dq = rd_pipe_ff[P-1] ? mem_ff[col_pipe_ff[P-1]] : dq_ff;
    nxt_wr_pend = wr_cmd;
    nxt_wcol = wr_cmd ? IW'(bus.addr) : wcol_ff;
    // Strobe timing is not checked: late or long strobes still write
    wr_word = mem_ff[wcol_ff]; // see [RQ13] see [RQ14]
    for (int b = 0; b < NS; b++) begin
      if (!bus.dm[b]) begin
        wr_word[b*BYTE_W +: BYTE_W] = bus.dq[b*BYTE_W +: BYTE_W]; // see [RQ11]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_ACTIVE;
      rd_pipe_ff <= '0;
      wr_pend_ff <= 1'b0;
      wcol_ff <= '0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      for (int i = 0; i < P; i++) begin
        col_pipe_ff[i] <= '0;
      end
    end else begin
      mode_ff <= nxt_mode;
      rd_pipe_ff <= nxt_rd_pipe;
      wr_pend_ff <= nxt_wr_pend;
      wcol_ff <= nxt_wcol;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      for (int i = 0; i < P; i++) begin
        col_pipe_ff[i] <= nxt_col_pipe[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_pend_ff) begin
      mem_ff[wcol_ff] <= wr_word;
    end
  end
endmodule // lctr_mem

/* tb/lctr_assertions.sv */
// Checker for the command bus joining the two ends.
// Assumes the fast grade, the default CL and the default bus widths.
`timescale 1ns/10ps
module lctr_assertions
  import lctr_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int NS = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ck_run,
  input wire logic cke,
  input wire lctr_cmd_t cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dq_c_oe,
  input wire logic [NS-1:0] dqs_c_oe,
  input wire logic dq_m_oe,
  input wire logic [NS-1:0] dqs
);
  // ---------------------------------------------------------------
  // Cycle counts and helper counters
  // ---------------------------------------------------------------
  // Data flops load CL-1 edges after the command edge and are seen one edge later
  localparam int RDLAT = CL_DEF;
  localparam int RAS_CYC = (RAS_FAST_PS + CLK_PS - 1) / CLK_PS;
  localparam int DAL_CYC = (WR_FAST_PS + CLK_PS - 1) / CLK_PS + (RP_FAST_PS + CLK_PS - 1) / CLK_PS;
  localparam int XSR_CYC = (XSR_FAST_PS + CLK_PS - 1) / CLK_PS;
  logic [7:0] row_cnt_ff, nxt_row_cnt, dal_cnt_ff, nxt_dal_cnt, xsr_cnt_ff, nxt_xsr_cnt;
  logic sref_ff, nxt_sref, cke_ff;

  always_comb begin
    nxt_row_cnt = (cmd == CMD_ACT) ? 8'(RAS_CYC - 1) : ((row_cnt_ff != 8'h00) ? row_cnt_ff - 8'h01 : 8'h00);
    nxt_dal_cnt = (cmd == CMD_WR && addr[AP_BIT]) ? 8'(DAL_CYC - 1) : ((dal_cnt_ff != 8'h00) ? dal_cnt_ff - 8'h01 : 8'h00);
    nxt_sref = (cmd == CMD_REF && !cke) ? 1'b1 : ((cke && !cke_ff) ? 1'b0 : sref_ff);
    nxt_xsr_cnt = (cke && !cke_ff && sref_ff) ? 8'(XSR_CYC - 1) : ((xsr_cnt_ff != 8'h00) ? xsr_cnt_ff - 8'h01 : 8'h00);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_cnt_ff <= 8'h00;
      dal_cnt_ff <= 8'h00;
      xsr_cnt_ff <= 8'h00;
      sref_ff <= 1'b0;
      cke_ff <= 1'b1;
    end else begin
      row_cnt_ff <= nxt_row_cnt;
      dal_cnt_ff <= nxt_dal_cnt;
      xsr_cnt_ff <= nxt_xsr_cnt;
      sref_ff <= nxt_sref;
      cke_ff <= cke;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_beat;
    dq_m_oe ##1 !dq_m_oe;
  endsequence
  sequence s_wr_pre;
    dqs_c_oe == '1 && dqs == '0;
  endsequence
  sequence s_wr_data;
    dq_c_oe && dqs == '1;
  endsequence

  property p_xp_wait;
    $rose(cke) |-> (cmd == CMD_NOP) [*2];
  endproperty
  property p_xsr_wait;
    (xsr_cnt_ff != 8'h00) |-> cmd == CMD_NOP && ck_run;
  endproperty
  property p_read_lat;
    cmd == CMD_RD |-> ##RDLAT s_rd_beat;
  endproperty
  property p_drive_cause;
    $rose(dq_m_oe) |-> $past(cmd, RDLAT) == CMD_RD;
  endproperty
  property p_ras_pre;
    cmd == CMD_PRE |-> row_cnt_ff == 8'h00;
  endproperty
  property p_ap_gate;
    (cmd == CMD_RD || cmd == CMD_WR) && addr[AP_BIT] |-> row_cnt_ff == 8'h00;
  endproperty
  property p_dal;
    cmd == CMD_ACT |-> dal_cnt_ff == 8'h00;
  endproperty
  property p_wr_strobe;
    cmd == CMD_WR |-> s_wr_pre ##1 s_wr_data;
  endproperty
  property p_cke_low;
    $fell(cke) |-> (!cke && ck_run) [*2];
  endproperty
  property p_clk_stop;
    $fell(ck_run) |-> !cke;
  endproperty

  a_xp_wait: assert property (p_xp_wait) else $error("command too soon after clock enable rise");
  a_xsr_wait: assert property (p_xsr_wait) else $error("command or stopped clock in self refresh exit");
  a_read_lat: assert property (p_read_lat) else $error("read data not driven at latency");
  a_drive_cause: assert property (p_drive_cause) else $error("memory drive without read");
  a_ras_pre: assert property (p_ras_pre) else $error("precharge before row time");
  a_ap_gate: assert property (p_ap_gate) else $error("auto precharge access before row time");
  a_dal: assert property (p_dal) else $error("activate before write recovery plus precharge");
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe lanes wrong");
  a_cke_low: assert property (p_cke_low) else $error("clock enable low too short");
  a_clk_stop: assert property (p_clk_stop) else $error("clock stopped while awake");
endmodule // lctr_assertions

/* tb/lpddr_command_timing_rules_test.sv */
// Testbench joining controller and memory ends through the bus interface.
// Assumes default parameters: fast grade, automotive refresh, CL 3.
`timescale 1ns/10ps
module lpddr_command_timing_rules_test;
  import lctr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, rd_valid, freq_ok;
  lctr_op_t req_op = OP_READ;
  logic req_ap = 1'b0;
  logic [13:0] req_row = 14'h0000;
  logic [9:0] req_col = 10'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_mask = 2'h0;
  logic rd_ready = 1'b0;
  logic [15:0] rd_data;
  lctr_mode_t mem_mode;
  int error_cnt = 0;
  int tests_run = 0;

  always #2 core_clk = ~core_clk;

  lctr_if lctr_if_i ();
  lctr_ctrl lctr_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .bus(lctr_if_i), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_ap(req_ap), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .req_mask(req_mask), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .freq_ok(freq_ok));
  lctr_mem lctr_mem_i (.core_clk(core_clk), .rst_n(rst_n), .bus(lctr_if_i), .mem_mode(mem_mode));
  lctr_assertions #(.ADDR_W(14), .NS(2)) lctr_assertions_i (.core_clk(core_clk), .rst_n(rst_n),
    .ck_run(lctr_if_i.ck_run), .cke(lctr_if_i.cke), .cmd(lctr_if_i.cmd), .addr(lctr_if_i.addr),
    .dq_c_oe(lctr_if_i.dq_c_oe), .dqs_c_oe(lctr_if_i.dqs_c_oe), .dq_m_oe(lctr_if_i.dq_m_oe),
    .dqs(lctr_if_i.dqs));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    error_cnt++;
    $display("wrong value %s expected done seen timeout", what);
    final_report();
  endtask

  // Ready is sampled mid-cycle so the taking edge is never raced
  task automatic send(input lctr_op_t op, input logic ap, input logic [9:0] col, input logic [15:0] data,
      input logic [1:0] mask, input int bound, output bit got);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_ap <= ap;
    req_row <= 14'h0123;
    req_col <= col;
    req_wdata <= data;
    req_mask <= mask;
    got = 1'b0;
    for (int i = 0; i < bound && !got; i++) begin
      @(negedge core_clk);
      if (req_ready === 1'b1) got = 1'b1;
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask

  task automatic req(input lctr_op_t op, input logic ap, input logic [9:0] col, input logic [15:0] data,
      input logic [1:0] mask);
    bit got;
    send(op, ap, col, data, mask, 2000, got);
    if (!got) give_up("request taken");
  endtask

  task automatic get_rd(input string what, input logic [15:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 300);
    if (rd_valid !== 1'b1) give_up(what);
    chk(what, exp, rd_data);
    @(posedge core_clk);
    rd_ready <= 1'b1;
    @(posedge core_clk);
    rd_ready <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_write_read();
    req(OP_WRITE, 1'b1, 10'h003, 16'hA5C3, 2'h0);
    req(OP_WRITE, 1'b0, 10'h005, 16'h5A3C, 2'h0);
    req(OP_WRITE, 1'b1, 10'h003, 16'h1234, 2'h2);
    req(OP_READ, 1'b1, 10'h003, 16'h0000, 2'h0);
    get_rd("masked word", 16'hA534);
    req(OP_READ, 1'b0, 10'h005, 16'h0000, 2'h0);
    get_rd("plain word", 16'h5A3C);
    $display("test write_read done");
  endtask

  // Receiver stalls: two words wait, a third read must be held off
  task automatic t_buffer();
    bit got;
    req(OP_READ, 1'b0, 10'h003, 16'h0000, 2'h0);
    req(OP_READ, 1'b1, 10'h005, 16'h0000, 2'h0);
    send(OP_READ, 1'b0, 10'h003, 16'h0000, 2'h0, 150, got);
    chk("third read refused", 16'h0000, {15'h0000, got});
    get_rd("first buffered word", 16'hA534);
    get_rd("second buffered word", 16'h5A3C);
    @(negedge core_clk);
    chk("buffer empty", 16'h0000, {15'h0000, rd_valid});
    $display("test buffer done");
  endtask

  task automatic t_power(input lctr_op_t op, input lctr_mode_t m);
    int n;
    req(op, 1'b0, 10'h000, 16'h0000, 2'h0);
    n = 0;
    while (freq_ok !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (freq_ok !== 1'b1) give_up("clock stop");
    chk("low power mode", 16'(m), 16'(mem_mode));
    chk("frequency change allowed", 16'h0001, {15'h0000, freq_ok});
    req(OP_WAKE, 1'b0, 10'h000, 16'h0000, 2'h0);
    req(OP_READ, 1'b0, 10'h005, 16'h0000, 2'h0);
    chk("awake mode", 16'(MODE_ACTIVE), 16'(mem_mode));
    chk("frequency change closed", 16'h0000, {15'h0000, freq_ok});
    get_rd("word after wake", 16'h5A3C);
    $display("test power %0d done", m);
  endtask

  task automatic t_refresh();
    int gap;
    // Early gaps may hold a refresh delayed by traffic; the third is clean
    for (int k = 0; k < 3; k++) begin
      gap = 0;
      do begin
        @(negedge core_clk);
        gap++;
      end while (lctr_if_i.cmd !== CMD_REF && gap < 2100);
      if (lctr_if_i.cmd !== CMD_REF) give_up("refresh seen");
    end
    chk("refresh gap", 16'(REFI_NS * 1000 / CLK_PS / AUTO_DIV), 16'(gap));
    $display("test refresh done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_write_read();
    t_buffer();
    t_power(OP_PDN, MODE_PDN);
    t_power(OP_SREF, MODE_SREF);
    t_refresh();
    final_report();
  end
endmodule // lpddr_command_timing_rules_test
